// >>> soe_pkg.sv
// constants and types for the offset, exposure and sync register bank
// What this block does
// - auto offset enable hands the red offset register to internal calibration
// - offsets and biases are sign-magnitude: bit 7 set subtracts bits 6:0
// - auto mode lowers exposure and gain when average exceeds high threshold
// - auto mode raises exposure and gain when average is below low threshold
// - fast mode alone allows large steps beyond the nibble thresholds
// - four manual biases apply only with manual offset enable; reset 0x80
// - line interval enable adds a 10-bit extension from control bits 6:5
// - each extension count adds 2/1520 or 2/800 of a frame period
// - vsync is 4 lines wide; each low width count adds one line
// - each high width count adds 256 lines, forming a 16-bit extension
// - average update enable refreshes luma average with channel sum over 4
// - hsync start is 10 bits: control bits 1:0 over start register
// - hsync end is 10 bits: control bits 3:2 over end register
package soe_pkg;
	localparam logic [7:0] SOE_ADDR_RED_OFF    = 8'h23;
	localparam logic [7:0] SOE_ADDR_LUMA_HI    = 8'h24;
	localparam logic [7:0] SOE_ADDR_LUMA_LO    = 8'h25;
	localparam logic [7:0] SOE_ADDR_FAST_TH    = 8'h26;
	localparam logic [7:0] SOE_ADDR_B_BIAS     = 8'h27;
	localparam logic [7:0] SOE_ADDR_GB_BIAS    = 8'h28;
	localparam logic [7:0] SOE_ADDR_GR_BIAS    = 8'h29;
	localparam logic [7:0] SOE_ADDR_LINE_CTL   = 8'h2A;
	localparam logic [7:0] SOE_ADDR_LINE_LO    = 8'h2B;
	localparam logic [7:0] SOE_ADDR_R_BIAS     = 8'h2C;
	localparam logic [7:0] SOE_ADDR_VS_LO      = 8'h2D;
	localparam logic [7:0] SOE_ADDR_VS_HI      = 8'h2E;
	localparam logic [7:0] SOE_ADDR_LUMA_AVG   = 8'h2F;
	localparam logic [7:0] SOE_ADDR_HS_START   = 8'h30;
	localparam logic [7:0] SOE_ADDR_HS_END     = 8'h31;
	localparam logic [7:0] SOE_RST_RED_OFF     = 8'hEF;
	localparam logic [7:0] SOE_RST_LUMA_HI     = 8'hA0;
	localparam logic [7:0] SOE_RST_LUMA_LO     = 8'h88;
	localparam logic [7:0] SOE_RST_FAST_TH     = 8'hF4;
	localparam logic [7:0] SOE_RST_BIAS        = 8'h80;
	localparam logic [7:0] SOE_RST_ZERO        = 8'h00;
	localparam logic [7:0] SOE_RST_HS_START    = 8'h08;
	localparam logic [7:0] SOE_RST_HS_END      = 8'h30;
	// line control field positions
	localparam int         SOE_LINE_EN_BIT     = 7;
	localparam int         SOE_LINE_MSB_HI     = 6;
	localparam int         SOE_LINE_MSB_LO     = 5;
	localparam int         SOE_HS_END_HI       = 3;
	localparam int         SOE_HS_END_LO       = 2;
	localparam int         SOE_HS_START_HI     = 1;
	localparam int         SOE_HS_START_LO     = 0;
	localparam logic [7:0] SOE_LINE_CTL_WMASK  = 8'hEF;
	localparam int         SOE_SIGN_BIT        = 7;
	// frame fraction per extension count, numerator over lines
	localparam int         SOE_EXT_NUM         = 2;
	localparam int         SOE_EXT_DEN_FULL    = 1520;
	localparam int         SOE_EXT_DEN_REDUCED = 800;
	localparam logic [3:0] SOE_VS_BASE_LINES   = 4'h4;
	localparam logic [1:0] SOE_AVG_SHIFT       = 2'h2;
	localparam int         SOE_NUM_CHAN        = 4;
	typedef enum logic [1:0] {
		SOE_AE_HOLD = 2'b00,
		SOE_AE_UP   = 2'b01,
		SOE_AE_DOWN = 2'b11
	} soe_ae_dir_t;
endpackage

// >>> soe_sm_adj.sv
// sign-magnitude offset applied to a pixel sample, with clamping
`timescale 1ns/1ps
module soe_sm_adj
	import soe_pkg::*;
#(
	parameter int W = 10
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// data
	input  wire logic [W-1:0] pix_in,
	input  wire logic [7:0]   offset_in,
	output logic [W-1:0]      pix_out
);
	logic [W:0] mag;
	logic [W:0] sum;
	// the magnitude field is 7 bits, so a narrower sample cannot hold it
	if (W < 7) begin : g_bad_width
		$error("soe_sm_adj: width below magnitude");
	end
	assign mag = (W+1)'(offset_in[6:0]);
	// bit 7 set subtracts the magnitude, clear adds it
	always_comb begin
		if (offset_in[SOE_SIGN_BIT]) begin
			sum = {1'b0, pix_in} - mag;
		end else begin
			sum = {1'b0, pix_in} + mag;
		end
	end
	// clamp rather than wrap: a wrapped black level shows as white speckle
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pix_out <= '0;
		end else if (sum[W]) begin
			pix_out <= offset_in[SOE_SIGN_BIT] ? '0 : '1;
		end else begin
			pix_out <= sum[W-1:0];
		end
	end
endmodule

// >>> soe_regs.sv
// register bank: channel offsets, exposure thresholds, line and sync timing
`timescale 1ns/1ps
module soe_regs
	import soe_pkg::*;
#(
	parameter int PIX_W = 10
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// register port
	input  wire logic [7:0]       reg_addr_in,
	input  wire logic [7:0]       reg_wdata_in,
	input  wire logic             reg_wr_in,
	input  wire logic             reg_rd_in,
	output logic [7:0]            reg_rdata_out,
	// mode bits from other control registers
	input  wire logic             auto_offset_en_in,
	input  wire logic             manual_offset_en_in,
	input  wire logic             fast_mode_en_in,
	input  wire logic             avg_update_en_in,
	input  wire logic             reduced_res_in,
	// calibration and statistics
	input  wire logic [7:0]       auto_red_offset_in,
	input  wire logic             auto_red_offset_vld_in,
	input  wire logic [7:0]       blue_average_in,
	input  wire logic [7:0]       green_blue_average_in,
	input  wire logic [7:0]       green_red_average_in,
	input  wire logic [7:0]       red_average_in,
	input  wire logic             average_vld_in,
	// pixel path, channels blue, green-blue, green-red, red
	input  wire logic [4*PIX_W-1:0] pix_in,
	output logic [4*PIX_W-1:0]    pix_out,
	// exposure loop
	output logic                  ae_raise_out,
	output logic                  ae_lower_out,
	output logic                  ae_fast_out,
	// timing
	output logic [9:0]            line_ext_out,
	output logic [10:0]           line_ext_den_out,
	output logic [16:0]           vsync_lines_out,
	output logic [9:0]            hsync_start_out,
	output logic [9:0]            hsync_end_out
);
	logic [7:0]       red_off_q;
	logic [7:0]       luma_hi_q;
	logic [7:0]       luma_lo_q;
	logic [7:0]       fast_th_q;
	logic [7:0]       bias_q [SOE_NUM_CHAN];
	logic [7:0]       line_ctl_q;
	logic [7:0]       line_lo_q;
	logic [7:0]       vs_lo_q;
	logic [7:0]       vs_hi_q;
	logic [7:0]       luma_avg_q;
	logic [7:0]       hs_start_q;
	logic [7:0]       hs_end_q;
	logic [7:0]       rdata_d;
	logic [3:0]       bias_sel;
	logic [9:0]       avg_sum;
	logic [7:0]       chan_off [SOE_NUM_CHAN];
	logic [7:0]       fixed_off [SOE_NUM_CHAN];
	soe_ae_dir_t      ae_dir_d;
	logic             fast_d;

	if (PIX_W < 8 || PIX_W > 16) begin : g_bad_pix_w
		$error("soe_regs: PIX_W out of range");
	end

	function automatic logic wr_hit(input logic [7:0] a);
		return reg_wr_in && (reg_addr_in == a);
	endfunction

	function automatic logic [3:0] bias_index(input logic [7:0] a);
		case (a)
			SOE_ADDR_B_BIAS:  return 4'h1;
			SOE_ADDR_GB_BIAS: return 4'h2;
			SOE_ADDR_GR_BIAS: return 4'h4;
			SOE_ADDR_R_BIAS:  return 4'h8;
			default:          return 4'h0;
		endcase
	endfunction

	// red offset: calibration owns it while auto offset is on
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			red_off_q <= SOE_RST_RED_OFF;
		end else if (auto_offset_en_in && auto_red_offset_vld_in) begin
			red_off_q <= auto_red_offset_in;
		end else if (!auto_offset_en_in && wr_hit(SOE_ADDR_RED_OFF)) begin
			red_off_q <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			luma_hi_q <= SOE_RST_LUMA_HI;
			luma_lo_q <= SOE_RST_LUMA_LO;
			fast_th_q <= SOE_RST_FAST_TH;
		end else begin
			if (wr_hit(SOE_ADDR_LUMA_HI)) begin
				luma_hi_q <= reg_wdata_in;
			end
			if (wr_hit(SOE_ADDR_LUMA_LO)) begin
				luma_lo_q <= reg_wdata_in;
			end
			if (wr_hit(SOE_ADDR_FAST_TH)) begin
				fast_th_q <= reg_wdata_in;
			end
		end
	end

	// manual biases, order blue, green-blue, green-red, red
	assign bias_sel = bias_index(reg_addr_in);
	genvar gi;
	generate
		for (gi = 0; gi < SOE_NUM_CHAN; gi++) begin : g_bias
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					bias_q[gi] <= SOE_RST_BIAS;
				end else if (reg_wr_in && bias_sel[gi]) begin
					bias_q[gi] <= reg_wdata_in;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			line_ctl_q <= SOE_RST_ZERO;
			line_lo_q  <= SOE_RST_ZERO;
			vs_lo_q    <= SOE_RST_ZERO;
			vs_hi_q    <= SOE_RST_ZERO;
			hs_start_q <= SOE_RST_HS_START;
			hs_end_q   <= SOE_RST_HS_END;
		end else begin
			if (wr_hit(SOE_ADDR_LINE_CTL)) begin
				// bit 4 is reserved and stays zero
				line_ctl_q <= reg_wdata_in & SOE_LINE_CTL_WMASK;
			end
			if (wr_hit(SOE_ADDR_LINE_LO)) begin
				line_lo_q <= reg_wdata_in;
			end
			if (wr_hit(SOE_ADDR_VS_LO)) begin
				vs_lo_q <= reg_wdata_in;
			end
			if (wr_hit(SOE_ADDR_VS_HI)) begin
				vs_hi_q <= reg_wdata_in;
			end
			if (wr_hit(SOE_ADDR_HS_START)) begin
				hs_start_q <= reg_wdata_in;
			end
			if (wr_hit(SOE_ADDR_HS_END)) begin
				hs_end_q <= reg_wdata_in;
			end
		end
	end

	// channel sum is 10 bits so four full-scale averages never overflow
	assign avg_sum = 10'(blue_average_in) + 10'(green_blue_average_in)
		+ 10'(green_red_average_in) + 10'(red_average_in);

	// hardware refresh wins over a software write in the same cycle
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			luma_avg_q <= SOE_RST_ZERO;
		end else if (avg_update_en_in && average_vld_in) begin
			luma_avg_q <= avg_sum[9:SOE_AVG_SHIFT];
		end else if (wr_hit(SOE_ADDR_LUMA_AVG)) begin
			luma_avg_q <= reg_wdata_in;
		end
	end

	always_comb begin
		case (reg_addr_in)
			SOE_ADDR_RED_OFF:  rdata_d = red_off_q;
			SOE_ADDR_LUMA_HI:  rdata_d = luma_hi_q;
			SOE_ADDR_LUMA_LO:  rdata_d = luma_lo_q;
			SOE_ADDR_FAST_TH:  rdata_d = fast_th_q;
			SOE_ADDR_B_BIAS:   rdata_d = bias_q[0];
			SOE_ADDR_GB_BIAS:  rdata_d = bias_q[1];
			SOE_ADDR_GR_BIAS:  rdata_d = bias_q[2];
			SOE_ADDR_LINE_CTL: rdata_d = line_ctl_q;
			SOE_ADDR_LINE_LO:  rdata_d = line_lo_q;
			SOE_ADDR_R_BIAS:   rdata_d = bias_q[3];
			SOE_ADDR_VS_LO:    rdata_d = vs_lo_q;
			SOE_ADDR_VS_HI:    rdata_d = vs_hi_q;
			SOE_ADDR_LUMA_AVG: rdata_d = luma_avg_q;
			SOE_ADDR_HS_START: rdata_d = hs_start_q;
			SOE_ADDR_HS_END:   rdata_d = hs_end_q;
			default:           rdata_d = SOE_RST_ZERO;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= SOE_RST_ZERO;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_d;
		end else begin
			reg_rdata_out <= SOE_RST_ZERO;
		end
	end

	// exposure direction, strict compares leave the band inclusive
	always_comb begin
		if (luma_avg_q > luma_hi_q) begin
			ae_dir_d = SOE_AE_DOWN;
		end else if (luma_avg_q < luma_lo_q) begin
			ae_dir_d = SOE_AE_UP;
		end else begin
			ae_dir_d = SOE_AE_HOLD;
		end
	end

	// nibble thresholds compared against the upper nibble of the average
	assign fast_d = fast_mode_en_in
		&& ((luma_avg_q[7:4] > fast_th_q[7:4])
		|| (luma_avg_q[7:4] < fast_th_q[3:0]));

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ae_raise_out <= 1'b0;
			ae_lower_out <= 1'b0;
			ae_fast_out  <= 1'b0;
		end else begin
			ae_raise_out <= (ae_dir_d == SOE_AE_UP);
			ae_lower_out <= (ae_dir_d == SOE_AE_DOWN);
			ae_fast_out  <= fast_d && (ae_dir_d != SOE_AE_HOLD);
		end
	end

	// timing values; the frame fraction per count is reported as a divisor
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			line_ext_out     <= '0;
			line_ext_den_out <= 11'(SOE_EXT_DEN_FULL / SOE_EXT_NUM);
			vsync_lines_out  <= '0;
			hsync_start_out  <= '0;
			hsync_end_out    <= '0;
		end else begin
			line_ext_out <= line_ctl_q[SOE_LINE_EN_BIT]
				? {line_ctl_q[SOE_LINE_MSB_HI:SOE_LINE_MSB_LO], line_lo_q}
				: 10'h000;
			line_ext_den_out <= reduced_res_in
				? 11'(SOE_EXT_DEN_REDUCED / SOE_EXT_NUM)
				: 11'(SOE_EXT_DEN_FULL / SOE_EXT_NUM);
			vsync_lines_out <= 17'(SOE_VS_BASE_LINES)
				+ 17'({vs_hi_q, vs_lo_q});
			hsync_start_out <= {line_ctl_q[SOE_HS_START_HI:SOE_HS_START_LO],
				hs_start_q};
			hsync_end_out <= {line_ctl_q[SOE_HS_END_HI:SOE_HS_END_LO],
				hs_end_q};
		end
	end

	// offsets per channel: manual bias only while enabled, else fixed
	assign fixed_off[0] = SOE_RST_ZERO;
	assign fixed_off[1] = SOE_RST_ZERO;
	assign fixed_off[2] = SOE_RST_ZERO;
	assign fixed_off[3] = red_off_q;

	generate
		for (gi = 0; gi < SOE_NUM_CHAN; gi++) begin : g_chan
			assign chan_off[gi] = manual_offset_en_in
				? bias_q[gi] : fixed_off[gi];
			soe_sm_adj #(
				.W (PIX_W)
			) u_adj (
				.clk_in    (clk_in),
				.rst_n_in  (rst_n_in),
				.pix_in    (pix_in[gi*PIX_W +: PIX_W]),
				.offset_in (chan_off[gi]),
				.pix_out   (pix_out[gi*PIX_W +: PIX_W])
			);
		end
	endgenerate
endmodule

// >>> soe_regs_chk.sv
// assertions on the ports of the offset, exposure and sync register bank
`timescale 1ns/1ps
module soe_regs_chk
	import soe_pkg::*;
#(
	parameter int PIX_W = 10
) (
	// clock, reset and register writes
	input wire logic               clk_in,
	input wire logic               rst_n_in,
	input wire logic [7:0]         reg_addr_in,
	input wire logic [7:0]         reg_wdata_in,
	input wire logic               reg_wr_in,
	// mode inputs and pixels
	input wire logic               manual_offset_en_in,
	input wire logic               fast_mode_en_in,
	input wire logic               reduced_res_in,
	input wire logic [4*PIX_W-1:0] pix_in,
	input wire logic [4*PIX_W-1:0] pix_out,
	// derived outputs
	input wire logic               ae_raise_out,
	input wire logic               ae_lower_out,
	input wire logic               ae_fast_out,
	input wire logic [9:0]         line_ext_out,
	input wire logic [10:0]        line_ext_den_out,
	input wire logic [16:0]        vsync_lines_out,
	input wire logic [9:0]         hsync_start_out,
	input wire logic [9:0]         hsync_end_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// timing outputs lag a register write by two edges
	a_hs_start_low: assert property (
		reg_wr_in && reg_addr_in == SOE_ADDR_HS_START
		|=> ##1 hsync_start_out[7:0] == $past(reg_wdata_in, 2))
		else $error("hsync start low byte differs from write");
	a_hs_end_low: assert property (
		reg_wr_in && reg_addr_in == SOE_ADDR_HS_END
		|=> ##1 hsync_end_out[7:0] == $past(reg_wdata_in, 2))
		else $error("hsync end low byte differs from write");
	a_line_ext_off: assert property (
		reg_wr_in && reg_addr_in == SOE_ADDR_LINE_CTL && !reg_wdata_in[7]
		|=> ##1 line_ext_out == 10'h000)
		else $error("line extension active while disabled");
	a_vsync_low: assert property (
		reg_wr_in && reg_addr_in == SOE_ADDR_VS_LO
		|=> ##1 vsync_lines_out[7:0]
			== $past(reg_wdata_in, 2) + 8'(SOE_VS_BASE_LINES))
		else $error("vsync low byte differs from write plus base");
	a_vsync_floor: assert property (
		$past(rst_n_in) |-> vsync_lines_out >= 17'h00004)
		else $error("vsync width below base");
	a_den_full: assert property (
		(rst_n_in && !reduced_res_in) [*2]
		|-> line_ext_den_out == 11'(SOE_EXT_DEN_FULL / SOE_EXT_NUM))
		else $error("full resolution step wrong");
	a_den_reduced: assert property (
		(rst_n_in && reduced_res_in) [*2]
		|-> line_ext_den_out == 11'(SOE_EXT_DEN_REDUCED / SOE_EXT_NUM))
		else $error("reduced resolution step wrong");
	a_ae_one_way: assert property (
		!(ae_raise_out && ae_lower_out))
		else $error("exposure raised and lowered at once");
	a_fast_gated: assert property (
		!fast_mode_en_in [*3] |-> !ae_fast_out)
		else $error("fast step without fast mode");
	// blue lane has no offset source here while manual mode is off
	a_blue_pass: assert property (
		(rst_n_in && !manual_offset_en_in) [*2]
		|-> pix_out[PIX_W-1:0] == $past(pix_in[PIX_W-1:0]))
		else $error("blue lane altered without manual bias");
	c_raise: cover property ($rose(ae_raise_out));
	c_lower: cover property ($rose(ae_lower_out));
	c_fast: cover property ($rose(ae_fast_out));
endmodule

// >>> tb_soe_regs.sv
// testbench for the offset, exposure and sync register bank
`timescale 1ns/1ps
module tb_soe_regs
	import soe_pkg::*;
();
	logic        clk_in, rst_n_in, reg_wr_in, reg_rd_in, average_vld_in;
	logic        auto_offset_en_in, manual_offset_en_in, fast_mode_en_in;
	logic        avg_update_en_in, reduced_res_in, auto_red_offset_vld_in;
	logic        ae_raise_out, ae_lower_out, ae_fast_out;
	logic [2:0]  ae;
	logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, auto_red_offset_in;
	logic [7:0]  av [4];
	logic [39:0] pix_in, pix_out;
	logic [9:0]  line_ext_out, hsync_start_out, hsync_end_out;
	logic [10:0] line_ext_den_out;
	logic [16:0] vsync_lines_out;
	int          n_mismatch, n_tests;
	localparam logic [7:0] RST [15] = '{8'hEF, 8'hA0, 8'h88, 8'hF4, 8'h80,
		8'h80, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h08, 8'h30};
	localparam logic [31:0] AV [5] = '{32'h4330_2010, 32'hC0C0_C0C0,
		32'h8888_8888, 32'hA1A0_A0A0, 32'hFFFF_FFFF};
	// average, then raise, lower, fast
	localparam logic [10:0] EX [5] = '{{8'h28, 3'h5}, {8'hC0, 3'h2},
		{8'h88, 3'h0}, {8'hA0, 3'h0}, {8'hFF, 3'h3}};

	assign ae = {ae_raise_out, ae_lower_out, ae_fast_out};

	soe_regs #(.PIX_W(10)) dut (.clk_in, .rst_n_in, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
		.auto_offset_en_in, .manual_offset_en_in, .fast_mode_en_in,
		.avg_update_en_in, .reduced_res_in, .auto_red_offset_in,
		.auto_red_offset_vld_in, .blue_average_in(av[0]),
		.green_blue_average_in(av[1]), .green_red_average_in(av[2]),
		.red_average_in(av[3]), .average_vld_in, .pix_in, .pix_out,
		.ae_raise_out, .ae_lower_out, .ae_fast_out, .line_ext_out,
		.line_ext_den_out, .vsync_lines_out, .hsync_start_out,
		.hsync_end_out);

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [39:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, exp);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		chk("read data", reg_rdata_out, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	initial begin
		#1000000;
		n_mismatch++;
		test_done();
	end

	initial begin
		{rst_n_in, reg_wr_in, reg_rd_in, average_vld_in} = 4'h0;
		{auto_offset_en_in, manual_offset_en_in, fast_mode_en_in} = 3'h0;
		{avg_update_en_in, reduced_res_in, auto_red_offset_vld_in} = 3'h0;
		{reg_addr_in, reg_wdata_in, auto_red_offset_in} = 24'h000000;
		av = '{8'h00, 8'h00, 8'h00, 8'h00};
		pix_in = {10'h3C0, 10'h010, 10'h020, 10'h3FF};
		n_mismatch = 0;
		n_tests = 0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 15; i++)
			rd(8'h23 + 8'(i), RST[i]);
		rd(8'h22, 8'h00);
		rd(8'h32, 8'h00);
		chk("vsync", vsync_lines_out, 17'h00004);
		chk("hs start", hsync_start_out, 10'h008);
		chk("hs end", hsync_end_out, 10'h030);
		chk("line ext", line_ext_out, 10'h000);
		chk("den", line_ext_den_out, 11'h2F8);
		wr(SOE_ADDR_LINE_CTL, 8'hFF);
		wr(SOE_ADDR_LINE_LO, 8'h34);
		wr(SOE_ADDR_VS_LO, 8'hFC);
		wr(SOE_ADDR_VS_HI, 8'h02);
		wr(SOE_ADDR_HS_START, 8'h12);
		wr(SOE_ADDR_HS_END, 8'h9A);
		@(posedge clk_in);
		reduced_res_in <= 1'b1;
		tick(3);
		rd(SOE_ADDR_LINE_CTL, 8'hEF);
		chk("line ext", line_ext_out, 10'h334);
		chk("vsync", vsync_lines_out, 17'h00300);
		chk("hs start", hsync_start_out, 10'h312);
		chk("hs end", hsync_end_out, 10'h39A);
		chk("den", line_ext_den_out, 11'h190);
		wr(SOE_ADDR_LINE_CTL, 8'h60);
		tick(3);
		chk("line ext", line_ext_out, 10'h000);
		// lower fast high threshold so a full-scale average can exceed it
		wr(SOE_ADDR_FAST_TH, 8'hE4);
		@(posedge clk_in);
		avg_update_en_in <= 1'b1;
		fast_mode_en_in <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_in);
			{av[3], av[2], av[1], av[0]} <= AV[i];
			average_vld_in <= 1'b1;
			@(posedge clk_in);
			average_vld_in <= 1'b0;
			tick(3);
			chk("ae", ae, EX[i][2:0]);
			rd(SOE_ADDR_LUMA_AVG, EX[i][10:3]);
		end
		@(posedge clk_in);
		fast_mode_en_in <= 1'b0;
		avg_update_en_in <= 1'b0;
		// dark averages would show up if the refresh ignored the enable
		{av[3], av[2], av[1], av[0]} <= 32'h0000_0000;
		average_vld_in <= 1'b1;
		@(posedge clk_in);
		average_vld_in <= 1'b0;
		tick(4);
		chk("ae", ae, 3'h2);
		rd(SOE_ADDR_LUMA_AVG, 8'hFF);
		@(posedge clk_in);
		auto_offset_en_in <= 1'b1;
		auto_red_offset_in <= 8'hD5;
		wr(SOE_ADDR_RED_OFF, 8'h11);
		rd(SOE_ADDR_RED_OFF, 8'hEF);
		@(posedge clk_in);
		auto_red_offset_vld_in <= 1'b1;
		@(posedge clk_in);
		auto_red_offset_vld_in <= 1'b0;
		rd(SOE_ADDR_RED_OFF, 8'hD5);
		tick(2);
		chk("pix", pix_out, {10'h36B, 10'h010, 10'h020, 10'h3FF});
		wr(SOE_ADDR_B_BIAS, 8'h05);
		wr(SOE_ADDR_GB_BIAS, 8'h83);
		wr(SOE_ADDR_R_BIAS, 8'hFF);
		tick(2);
		chk("pix", pix_out, {10'h36B, 10'h010, 10'h020, 10'h3FF});
		@(posedge clk_in);
		manual_offset_en_in <= 1'b1;
		tick(3);
		chk("pix", pix_out, {10'h341, 10'h010, 10'h01D, 10'h3FF});
		test_done();
	end
endmodule

bind soe_regs soe_regs_chk #(.PIX_W(PIX_W)) u_chk (.clk_in, .rst_n_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .manual_offset_en_in,
	.fast_mode_en_in, .reduced_res_in, .pix_in, .pix_out, .ae_raise_out,
	.ae_lower_out, .ae_fast_out, .line_ext_out, .line_ext_den_out,
	.vsync_lines_out, .hsync_start_out, .hsync_end_out);
